// File: design/ctimer_pkg.sv
// constants for the two-channel compare timer control block
`default_nettype none
package ctimer_pkg;
  // ----------------------------------------------------------------
  // structure
  // ----------------------------------------------------------------
  localparam int CH_NUM  = 2;            // channels
  localparam int NCMP    = 4;            // compare registers a..d
  localparam int NSRC    = 6;            // interrupt sources per channel
  localparam int CNT_W   = 16;           // counter width
  localparam int PRESC_W = 5;            // prescaler up to divide by 32
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] START_ADDR = 12'h000; // start register
  localparam logic [5:0]  CH0_PAGE   = 6'h01;   // channel 0 at 0x040
  localparam logic [5:0]  CH1_PAGE   = 6'h02;   // channel 1 at 0x080
  localparam logic [3:0]  IDX_CTRL   = 4'h0;    // channel control
  localparam logic [3:0]  IDX_IOCTL  = 4'h1;    // pin action control
  localparam logic [3:0]  IDX_STAT   = 4'h2;    // status flags
  localparam logic [3:0]  IDX_IEN    = 4'h3;    // interrupt enables
  localparam logic [3:0]  IDX_ICTL   = 4'h4;    // interrupt control
  localparam logic [3:0]  IDX_CNT    = 4'h5;    // channel counter
  localparam logic [3:0]  IDX_CMPA   = 4'h6;    // compare a, b..d follow
  localparam logic [3:0]  IDX_LAST   = 4'h9;    // compare d
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int STOPSEL_LSB = 2;        // stop select bits in start reg
  localparam int CS_LSB      = 0;        // count source select [2:0]
  localparam int CLR_LSB     = 5;        // counter clear select [7:5]
  localparam int REQ_BIT     = 3;        // request flag in irq control
  localparam int SRC_A       = 0;        // compare a match flag
  localparam int SRC_OVF     = 4;        // overflow flag
  localparam logic [2:0] CS_F1   = 3'h0; // peripheral clock
  localparam logic [2:0] CS_F2   = 3'h1;
  localparam logic [2:0] CS_F4   = 3'h2;
  localparam logic [2:0] CS_F8   = 3'h3;
  localparam logic [2:0] CS_F32  = 3'h4;
  localparam logic [2:0] CS_FAST = 3'h6; // fast internal oscillator
  localparam logic [2:0] CLR_A    = 3'h1;
  localparam logic [2:0] CLR_B    = 3'h2;
  localparam logic [2:0] CLR_SYNC = 3'h3;
  localparam logic [2:0] CLR_C    = 3'h5;
  localparam logic [2:0] CLR_D    = 3'h6;
  localparam logic [1:0] ACT_LOW  = 2'h1; // pin action on match
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TGL  = 2'h3;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [7:0]  IOCTL_RST = 8'h00;
  localparam logic [15:0] CMP_RST  = 16'hffff;
  localparam logic [2:0]  PRIO_RST = 3'h0;
endpackage
`default_nettype wire

// File: design/chan_if.sv
// carrier between the control top and one counter channel
`default_nettype none
interface chan_if;
  import ctimer_pkg::*;
  logic                tick;       // count enable pulse
  logic [2:0]          clrSel;     // counter clear select
  logic [7:0]          ioCtl;      // two action bits per compare
  logic [CNT_W-1:0]    cmp [NCMP]; // compare values
  logic                cntWr;      // software counter write
  logic [CNT_W-1:0]    cntWrData;  // value written
  logic                syncClr;    // other channel's own clear
  logic [CNT_W-1:0]    count;      // counter value
  logic [4:0]          events;     // overflow, match d..a
  logic                ownClr;     // clear caused by own compare
  logic [NCMP-1:0]     pins;       // compare output pins
  modport top  (output tick, clrSel, ioCtl, cmp, cntWr, cntWrData,
                syncClr, input count, events, ownClr, pins);
  modport chan (input tick, clrSel, ioCtl, cmp, cntWr, cntWrData,
                syncClr, output count, events, ownClr, pins);
endinterface
`default_nettype wire

// File: design/timer_channel.sv
// one 16-bit compare counter with clear select and pin actions
`default_nettype none
module timer_channel
  import ctimer_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  chan_if.chan     cif
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // compare and clear
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] count_r;  // counter
  logic [NCMP-1:0]  pins_r;   // pin levels
  logic [NCMP-1:0]  match;    // match while counting
  logic             clr;      // counter clear this cycle
  logic             ovf;      // wrap from all ones

  // matches count only on a count pulse, so a stopped counter is quiet
  for (genvar j = 0; j < NCMP; j++) begin : g_match
    assign match[j] = cif.tick & (count_r == cif.cmp[j]); // [R2]
  end

  // clear source decode, sync mode borrows the other channel
  always_comb begin
    case (cif.clrSel) // [R14]
      CLR_A:   cif.ownClr = match[0];
      CLR_B:   cif.ownClr = match[1];
      CLR_C:   cif.ownClr = match[2];
      CLR_D:   cif.ownClr = match[3];
      default: cif.ownClr = 1'b0; // free run, sync and illegal codes
    endcase
  end
  // own clear only is exported, so two sync channels form no loop
  assign clr = cif.ownClr | ((cif.clrSel == CLR_SYNC) & cif.syncClr);
  assign ovf = cif.tick & (count_r == '1) & ~clr; // [R2]
  assign cif.events = {ovf, match};
  assign cif.count  = count_r;
  assign cif.pins   = pins_r;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // a clear beats a colliding software write
  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= '0;
    end else if (clr) begin
      count_r <= '0; // [R15] [R20]
    end else if (cif.cntWr) begin
      count_r <= cif.cntWrData;
    end else if (cif.tick) begin
      count_r <= count_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pin actions
  // ----------------------------------------------------------------
  // pins move only on a match, so any stop keeps the last level
  for (genvar j = 0; j < NCMP; j++) begin : g_pin
    always_ff @(posedge clk) begin
      if (rst) begin
        pins_r[j] <= 1'b0;
      end else if (match[j]) begin // [R12] [R13]
        case (cif.ioCtl[2*j +: 2])
          ACT_LOW:  pins_r[j] <= 1'b0;
          ACT_HIGH: pins_r[j] <= 1'b1;
          ACT_TGL:  pins_r[j] <= ~pins_r[j]; // [R20]
          default:  pins_r[j] <= pins_r[j];
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_clear_wins: assert property (clr |=> count_r == '0) // [R15]
    else $error("counter not zero after clear");
  a_clear_sel_b: assert property ( // [R14]
    (cif.clrSel == CLR_B) && match[1] |=> count_r == '0)
    else $error("compare b clear missed");
  a_pins_hold: assert property (!cif.tick |=> $stable(pins_r)) // [R12]
    else $error("pin moved while not counting");
  a_toggle_a: assert property ( // [R20]
    match[0] && cif.ioCtl[1:0] == ACT_TGL |=> pins_r[0] != $past(pins_r[0]))
    else $error("pin a did not toggle");
endmodule
`default_nettype wire

// File: design/compare_timer_irq_and_count_control.sv
// two-channel compare timer: apb registers, start control, irq
// Operation
// R1 - six sources gathered into one request
// R2 - compare matches and overflow set flags
// R3 - request high when enabled flag set
// R4 - request drops when no enabled flag
// R5 - request stays while another source pending
// R6 - handler reads flags to find source
// R7 - acknowledge never clears flags, software does
// R8 - stop select zero: stop after a-clear
// R9 - stop select zero: start write zero ignored
// R10 - software writes start zero to keep it
// R11 - stop select first, start clear later
// R12 - software stop holds pin levels
// R13 - automatic stop holds match levels
// R14 - clear select codes a b sync c d
// R15 - clear beats colliding counter write
// R16 - read after write may be stale
// R17 - change count source only when stopped
// R18 - wait two cycles before oscillator off
// R19 - source code 110b selects fast oscillator
// R20 - clear and toggle on a, period n+1
// R21 - request combinational from status, enable
//
// Design decisions made here: the placing of the registers and the APB slave port.
`default_nettype none
module compare_timer_irq_and_count_control
  import ctimer_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fastOscClk,
  output logic [1:0]       irqRequest,
  output logic [5:0]       irqPriority,
  output logic [7:0]       comparePins,
  output logic [1:0]       countRunning
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic             accessPh;          // access phase
  logic             setupPh;           // setup phase
  logic             startSel;          // start register addressed
  logic [1:0]       chSel;             // channel page addressed
  logic [3:0]       regIdx;            // word within page
  logic             mapped;            // address is a register
  logic             startWr;           // start register write
  logic [1:0]       chanStart_r;       // channel start bits
  logic [1:0]       stopSel_r;         // stop select bits
  logic [7:0]       ctrl_r    [CH_NUM];// source and clear select
  logic [7:0]       ioCtl_r   [CH_NUM];// pin actions
  logic [NSRC-1:0]  statFlags_r [CH_NUM]; // status flags
  logic [NSRC-1:0]  irqEn_r   [CH_NUM];// interrupt enables
  logic [2:0]       prio_r    [CH_NUM];// priority levels
  logic [CNT_W-1:0] cmp_r [CH_NUM][NCMP]; // compare values
  logic [CNT_W-1:0] count [CH_NUM];    // counter readback
  logic [4:0]       events [CH_NUM];   // channel events
  logic [1:0]       ownClr;            // per channel own clears
  logic [1:0]       autoStop;          // a-match stop events
  logic [1:0]       tick;              // count pulses
  logic [31:0]      rdMux;             // read data before register

  assign setupPh  = psel & ~penable;
  assign accessPh = psel & penable;
  assign regIdx   = paddr[5:2];
  assign startSel = (paddr == START_ADDR);
  assign chSel[0] = (paddr[11:6] == CH0_PAGE) & (paddr[1:0] == 2'h0);
  assign chSel[1] = (paddr[11:6] == CH1_PAGE) & (paddr[1:0] == 2'h0);
  assign mapped   = startSel | ((|chSel) & (regIdx <= IDX_LAST));
  assign startWr  = accessPh & pwrite & startSel;
  // zero wait: every access finishes in its first access cycle
  assign pready   = 1'b1;
  assign pslverr  = accessPh & ~mapped;

  // ----------------------------------------------------------------
  // count sources
  // ----------------------------------------------------------------
  logic [PRESC_W-1:0] presc_r;   // shared divider for f/2..f/32
  logic [2:0]         oscSync_r; // fast oscillator pin synchroniser
  logic               fastEdge;  // one pulse per oscillator rise
  logic               fastLvl_r; // filtered oscillator level

  // free-running divider, all channels see the same phase
  always_ff @(posedge clk) begin
    if (rst) begin
      presc_r <= '0;
    end else begin
      presc_r <= presc_r + 1'b1;
    end
  end

  // oscillator sampled as a pin; each level must last two clk cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      oscSync_r <= '0;
    end else begin
      oscSync_r <= {oscSync_r[1:0], fastOscClk};
    end
  end
  // level taken only when the two late stages agree, so a one-cycle
  // glitch on the oscillator pin never counts
  always_ff @(posedge clk) begin
    if (rst) begin
      fastLvl_r <= 1'b0;
    end else if (oscSync_r[1] == oscSync_r[2]) begin
      fastLvl_r <= oscSync_r[2];
    end
  end
  assign fastEdge = oscSync_r[2] & oscSync_r[1] & ~fastLvl_r;

  // source select to one-cycle enable; external clock not built
  function automatic logic srcPulse(input logic [2:0] cs,
                                    input logic [PRESC_W-1:0] pc,
                                    input logic fe);
    case (cs)
      CS_F1:   srcPulse = 1'b1;
      CS_F2:   srcPulse = pc[0];
      CS_F4:   srcPulse = &pc[1:0];
      CS_F8:   srcPulse = &pc[2:0];
      CS_F32:  srcPulse = &pc;
      CS_FAST: srcPulse = fe; // [R19]
      default: srcPulse = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // start register
  // ----------------------------------------------------------------
  // stop select is judged on its old value, so a single write
  // setting stop select and clearing start leaves the count running
  always_ff @(posedge clk) begin
    if (rst) begin
      chanStart_r <= '0;
      stopSel_r   <= '0;
    end else begin
      for (int ch = 0; ch < CH_NUM; ch++) begin
        if (startWr) begin
          stopSel_r[ch] <= pwdata[STOPSEL_LSB + ch];
        end
        if (startWr && pwdata[ch]) begin
          chanStart_r[ch] <= 1'b1; // software start wins
        end else if (startWr && stopSel_r[ch]) begin
          chanStart_r[ch] <= 1'b0; // [R11]
        end else if (!stopSel_r[ch] && autoStop[ch]) begin
          chanStart_r[ch] <= 1'b0; // [R8] [R13]
        end
        // write of zero with stop select low keeps start [R9]
      end
    end
  end
  assign countRunning = chanStart_r;

  // ----------------------------------------------------------------
  // per-channel registers and counter
  // ----------------------------------------------------------------
  for (genvar ch = 0; ch < CH_NUM; ch++) begin : g_ch
    chan_if cif ();
    logic chWr;   // write to this channel page
    logic statWr; // status write

    assign chWr   = accessPh & pwrite & chSel[ch];
    assign statWr = chWr & (regIdx == IDX_STAT);
    assign tick[ch] = chanStart_r[ch] &
                      srcPulse(ctrl_r[ch][CS_LSB +: 3], presc_r, fastEdge);
    assign autoStop[ch] = events[ch][SRC_A];

    // channel hookup
    assign cif.tick      = tick[ch];
    assign cif.clrSel    = ctrl_r[ch][CLR_LSB +: 3];
    assign cif.ioCtl     = ioCtl_r[ch];
    assign cif.cmp       = cmp_r[ch];
    assign cif.cntWr     = chWr & (regIdx == IDX_CNT);
    assign cif.cntWrData = pwdata[CNT_W-1:0];
    assign cif.syncClr   = ownClr[1-ch];
    assign ownClr[ch]    = cif.ownClr;
    assign count[ch]     = cif.count;
    assign events[ch]    = cif.events;
    assign comparePins[NCMP*ch +: NCMP] = cif.pins;

    timer_channel timer_channel_i (
      .clk (clk),
      .rst (rst),
      .cif (cif)
    );

    // control, enables, priority and compare values
    always_ff @(posedge clk) begin
      if (rst) begin
        ctrl_r[ch]  <= CTRL_RST;
        ioCtl_r[ch] <= IOCTL_RST;
        irqEn_r[ch] <= '0;
        prio_r[ch]  <= PRIO_RST;
        for (int j = 0; j < NCMP; j++) begin
          cmp_r[ch][j] <= CMP_RST;
        end
      end else if (chWr) begin
        case (regIdx)
          IDX_CTRL:  ctrl_r[ch]  <= pwdata[7:0];
          IDX_IOCTL: ioCtl_r[ch] <= pwdata[7:0];
          IDX_IEN:   irqEn_r[ch] <= pwdata[NSRC-1:0];
          IDX_ICTL:  prio_r[ch]  <= pwdata[2:0];
          default: begin
            for (int j = 0; j < NCMP; j++) begin
              if (regIdx == IDX_CMPA + 4'(j)) begin
                cmp_r[ch][j] <= pwdata[CNT_W-1:0];
              end
            end
          end
        endcase
      end
    end

    // flags: write zero clears, a same-cycle event wins; top
    // source bit has no event in compare mode and stays zero
    always_ff @(posedge clk) begin
      if (rst) begin
        statFlags_r[ch] <= '0;
      end else if (statWr) begin
        statFlags_r[ch] <= (statFlags_r[ch] & pwdata[NSRC-1:0]) |
                           {1'b0, events[ch]}; // [R7] [R2]
      end else begin
        statFlags_r[ch] <= statFlags_r[ch] | {1'b0, events[ch]};
      end
    end

    // level request, never latched: follows flags and enables
    assign irqRequest[ch] = |(statFlags_r[ch] & irqEn_r[ch]); // [R1] [R3] [R4] [R5] [R21]
    assign irqPriority[3*ch +: 3] = prio_r[ch]; // [R1]

    a_flag_set_wins: assert property ( // [R7]
      statWr && events[ch][SRC_OVF] |=> statFlags_r[ch][SRC_OVF])
      else $error("overflow flag lost on clear");
    a_flag_keeps: assert property ( // [R7]
      statFlags_r[ch][SRC_A] && !statWr |=> statFlags_r[ch][SRC_A])
      else $error("flag cleared without software");
    a_irq_drops: assert property ( // [R4]
      statWr && pwdata[NSRC-1:0] == '0 && events[ch] == '0 &&
      !(chWr && regIdx == IDX_IEN) |=> !irqRequest[ch])
      else $error("request held after flags cleared");
    a_irq_stays: assert property ( // [R5]
      statFlags_r[ch][1] && irqEn_r[ch][1] && !statWr &&
      !(chWr && regIdx == IDX_IEN) |=> irqRequest[ch])
      else $error("request dropped with source pending");
    a_match_flag: assert property ( // [R2]
      events[ch][SRC_A] |=> statFlags_r[ch][SRC_A] && (irqRequest[ch]
      || !irqEn_r[ch][SRC_A]))
      else $error("match did not raise flag");
    a_auto_stop: assert property ( // [R8]
      !stopSel_r[ch] && autoStop[ch] && !(startWr && pwdata[ch])
      |=> !chanStart_r[ch] ##1 !tick[ch])
      else $error("counter did not stop after a-clear");
    a_start_kept: assert property ( // [R9] [R11]
      startWr && !pwdata[ch] && !stopSel_r[ch] && chanStart_r[ch] &&
      !autoStop[ch] |=> chanStart_r[ch])
      else $error("start bit dropped with stop select low");
    a_fast_src: assert property ( // [R19]
      ctrl_r[ch][CS_LSB +: 3] == CS_FAST && chanStart_r[ch] &&
      oscSync_r[2] && oscSync_r[1] && !fastLvl_r |-> tick[ch] ##1 !tick[ch])
      else $error("fast oscillator edge not counted");
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // read mux; unmapped and reserved bits read zero
  always_comb begin
    rdMux = '0;
    if (startSel) begin
      rdMux[1:0] = chanStart_r;
      rdMux[STOPSEL_LSB +: 2] = stopSel_r;
    end
    for (int ch = 0; ch < CH_NUM; ch++) begin
      if (chSel[ch]) begin
        case (regIdx)
          IDX_CTRL:  rdMux[7:0] = ctrl_r[ch];
          IDX_IOCTL: rdMux[7:0] = ioCtl_r[ch];
          IDX_STAT:  rdMux[NSRC-1:0] = statFlags_r[ch];
          IDX_IEN:   rdMux[NSRC-1:0] = irqEn_r[ch];
          IDX_ICTL:  rdMux[REQ_BIT:0] = {irqRequest[ch], prio_r[ch]};
          IDX_CNT:   rdMux[CNT_W-1:0] = count[ch];
          default: begin
            for (int j = 0; j < NCMP; j++) begin
              if (regIdx == IDX_CMPA + 4'(j)) begin
                rdMux[CNT_W-1:0] = cmp_r[ch][j];
              end
            end
          end
        endcase
      end
    end
  end

  // captured in setup, so a read right after a write may be stale
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
    end else if (setupPh && !pwrite) begin
      prdata <= rdMux; // [R16]
    end
  end
endmodule
`default_nettype wire

// File: verification/tb_compare_timer_irq_and_count_control.sv
// self-checking bench for the two-channel compare timer control block
`default_nettype none
module tb_compare_timer_irq_and_count_control;
  timeunit 1ns;
  timeprecision 1ps;
  import ctimer_pkg::*;
  // ----------------------------------------------------------------
  // signals and bookkeeping
  // ----------------------------------------------------------------
  typedef struct {logic [31:0] data; logic [31:0] mask; logic err;} note_s;
  logic        clk, rst, psel, penable, pwrite;  // bus and clock
  logic [11:0] paddr;                            // byte address
  logic [31:0] pwdata, prdata;                   // bus data
  logic        pready, pslverr;                  // slave answer
  logic        fastOscClk, fastRun;              // fast source, gate
  logic [1:0]  fdiv;                             // fast clock divider
  logic [1:0]  irqRequest, countRunning;         // per channel levels
  logic [5:0]  irqPriority;                      // two priority fields
  logic [7:0]  comparePins;                      // pins of both channels
  note_s       notes [$];                        // expected bus answers
  int          failCount, totalChecks;           // verdict counters
  integer      seed = 32'h5dec31d9;              // fixed random seed
  logic [31:0] rnd;                              // random draw
  logic [7:0]  ctrlTab [6] = '{8'hc0, 8'ha0, 8'h40, 8'h20, 8'h26, 8'h26};
  logic [7:0]  expTab [6]  = '{8'h08, 8'h0c, 8'h0e, 8'h0f, 8'h0f, 8'h00};
  compare_timer_irq_and_count_control compare_timer_irq_and_count_control_i (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fastOscClk(fastOscClk), .irqRequest(irqRequest),
    .irqPriority(irqPriority), .comparePins(comparePins),
    .countRunning(countRunning));
  // ----------------------------------------------------------------
  // clock, fast source and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // quarter-rate source, stands still while halted
  always @(posedge clk) begin
    fdiv <= fdiv + 2'h1;
    fastOscClk <= fastRun & fdiv[1];
  end
  function automatic logic [11:0] ra(input logic ch, input logic [3:0] idx);
    return {ch ? CH1_PAGE : CH0_PAGE, idx, 2'b00};
  endfunction
  task automatic endSim();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // one transfer; the answer is judged by the monitor below
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    notes.push_back('{d, w ? 32'h0 : m, e});
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // hold until pready seen; a lost answer ends the run
    if (pready !== 1'b1) begin
      failCount++;
      $display("[FAIL] %0t no pready", $time);
      endSim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 32'h0, 1'b0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    apb(a, 1'b0, e, m, 1'b0);
  endtask
  // port check at the settled falling edge: 0 irq, 1 run, 2 pins, 3 prio
  task automatic chk(input int k, input logic [7:0] e);
    logic [7:0] g;
    @(negedge clk);
    g = (k == 0) ? {6'h0, irqRequest} : (k == 1) ? {6'h0, countRunning} :
        (k == 2) ? comparePins : {2'h0, irqPriority};
    totalChecks++;
    if (g !== e) begin
      failCount++;
      $display("[FAIL] %0t port %0d got %h want %h", $time, k, g, e);
    end
  endtask
  // ----------------------------------------------------------------
  // monitor: oldest note against each completed transfer
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      totalChecks++;
      if (notes.size() == 0) begin
        failCount++;
        $display("[FAIL] %0t transfer with no note", $time);
      end else if (pslverr !== notes[0].err ||
          (prdata & notes[0].mask) !== (notes[0].data & notes[0].mask)) begin
        failCount++;
        $display("[FAIL] %0t bus answer %h err %b", $time, prdata, pslverr);
      end
      if (notes.size() != 0) void'(notes.pop_front());
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
    {fastRun, fdiv, fastOscClk, failCount, totalChecks} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    // reset values and unmapped places
    rd(ra(0, IDX_CMPA), 32'h0000ffff, 32'hffffffff);
    rd(START_ADDR, 32'h0, 32'hffffffff);
    apb(12'h068, 1'b0, 32'h0, 32'hffffffff, 1'b1);
    apb(12'h0fc, 1'b1, 32'h1, 32'h0, 1'b1);
    // start interlock with stop select clear
    wr(ra(0, IDX_CMPA), 32'h28);
    wr(ra(0, IDX_CMPA) + 12'h4, 32'h10);
    wr(ra(0, IDX_IOCTL), 32'h03);
    wr(ra(0, IDX_CTRL), 32'h20);
    wr(START_ADDR, 32'h01);
    chk(1, 8'h01);
    wr(START_ADDR, 32'h00);
    chk(1, 8'h01);
    wr(START_ADDR, 32'h04);
    chk(1, 8'h01);
    wr(START_ADDR, 32'h01);
    n = 0;
    while (countRunning[0] !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n == 100) begin
      failCount++;
      $display("[FAIL] %0t auto stop wait ran out", $time);
      endSim();
    end
    chk(1, 8'h00);
    chk(2, 8'h01);
    repeat (50) @(posedge clk);
    chk(2, 8'h01);
    rd(ra(0, IDX_CNT), 32'h0, 32'hffff);
    rd(ra(0, IDX_STAT), 32'h03, 32'hffffffff);
    // software stop holds the pin level
    wr(START_ADDR, 32'h04);
    wr(START_ADDR, 32'h05);
    repeat (20) @(posedge clk);
    wr(START_ADDR, 32'h04);
    chk(1, 8'h00);
    chk(2, 8'h01);
    // request gathering, priority fields
    rnd = $random(seed);
    wr(ra(0, IDX_ICTL), {29'h0, rnd[2:0]});
    wr(ra(1, IDX_ICTL), {29'h0, rnd[5:3]});
    chk(3, {2'h0, rnd[5:0]});
    chk(0, 8'h00);
    wr(ra(0, IDX_IEN), 32'h02);
    chk(0, 8'h01);
    wr(ra(0, IDX_IEN), 32'h3f);
    wr(ra(0, IDX_STAT), 32'h3e);
    chk(0, 8'h01);
    rd(ra(0, IDX_ICTL), {28'h0, 1'b1, rnd[2:0]}, 32'hf);
    rd(ra(0, IDX_STAT), 32'h02, 32'hffffffff);
    wr(ra(0, IDX_STAT), 32'h3c);
    chk(0, 8'h00);
    // counter write colliding with a clear on compare a
    wr(START_ADDR, 32'h05);
    wr(ra(0, IDX_CNT), 32'h26);
    wr(ra(0, IDX_CNT), {16'h0, 4'h1, rnd[19:8]});
    rd(ra(0, IDX_CNT), 32'h0, 32'hffc0);
    wr(START_ADDR, 32'h04);
    // clear select codes and count sources
    for (int i = 0; i < 4; i++) begin
      wr(ra(0, IDX_CMPA) + 12'(4 * i), 32'h30 - 32'(8 * i));
    end
    for (int i = 0; i < 6; i++) begin
      wr(START_ADDR, 32'h0c);
      wr(ra(0, IDX_CNT), 32'h0);
      wr(ra(0, IDX_STAT), 32'h0);
      wr(ra(0, IDX_CTRL), {24'h0, ctrlTab[i]});
      @(posedge clk);
      fastRun <= (i == 4);
      wr(START_ADDR, 32'h0d);
      repeat (400) @(posedge clk);
      wr(START_ADDR, 32'h0c);
      rd(ra(0, IDX_STAT), {24'h0, expTab[i]}, 32'hff);
      wr(ra(0, IDX_CTRL), 32'h20);
      repeat (2) @(posedge clk);
      fastRun <= 1'b0;
    end
    // channel 1 overflow and sync clear along with channel 0
    wr(ra(1, IDX_CMPA) + 12'h4, 32'h31);
    wr(ra(1, IDX_CTRL), 32'h60);
    wr(ra(1, IDX_CNT), 32'hfff0);
    wr(ra(1, IDX_IEN), 32'h10);
    wr(START_ADDR, 32'h0f);
    chk(1, 8'h03);
    repeat (200) @(posedge clk);
    chk(0, 8'h03);
    rd(ra(1, IDX_STAT), 32'h1d, 32'h3f);
    endSim();
  end
endmodule
`default_nettype wire
